// file: rtl/led_frame_pkg.sv
// constants for the led matrix frame map and completion status block
// assumes one 10 MHz clock, synchronous active-high reset and an apb master
// ============================================================
// What this block does
// - 17x7 frame one: rows nine bytes apart from 20h
// - 17x7 frame two same layout, 5fh to 9dh
// - 15x5 frame one: stride nine, fifteen columns
// - 15x5 frame two starts 4dh, ends 78h
// - scroll end flag sticky until scroll clear
// - fade end flag sticky until fade clear
// - palette fade flag sticky until its clear
// - interrupt pin is or of three flags
// - upper nibble earlier column, lower nibble next
// - low three bits duty select, top bit blink
package led_frame_pkg;
    // ============================================================
    // register indices, byte address is four times the index
    localparam logic [7:0] control_one_idx = 8'h01;
    localparam logic [7:0] pattern_first_idx = 8'h20;
    localparam logic [7:0] pattern_last_idx = 8'h9D;
    localparam logic [7:0] status_idx = 8'hFF;
    localparam int pattern_depth = 126;
    // ============================================================
    // field positions
    localparam int scroll_pos = 0;
    localparam int fade_pos = 1;
    localparam int palette_pos = 2;
    localparam int mode_pos = 4;
    localparam int blink_pos = 3;
    // ============================================================
    // layouts
    localparam logic [7:0] row_stride = 8'h09;
    localparam logic [7:0] wide_frame2_base = 8'h5F;
    localparam logic [7:0] narrow_frame2_base = 8'h4D;
    localparam logic [2:0] wide_rows = 3'h7;
    localparam logic [4:0] wide_cols = 5'h11;
    localparam logic [2:0] narrow_rows = 3'h5;
    localparam logic [4:0] narrow_cols = 5'h0F;
    // ============================================================
    // reset values
    localparam logic [2:0] flags_reset = 3'h0;
    localparam logic [31:0] data_reset = 32'h0000_0000;
    typedef enum logic {layout_wide, layout_narrow} layout_type;
endpackage : led_frame_pkg

// file: rtl/pattern_ram.sv
// two-frame pattern memory, one write port, one registered read port
// assumes write and read addresses are already range checked
`timescale 1ns/1ps
`default_nettype none
module pattern_ram (
    input wire logic clock,
    input wire logic wr_en,
    input wire logic [6:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [6:0] rd_addr,
    output logic [7:0] rd_data
);
    // contents are not reset: cleared by software like any frame buffer
    logic [7:0] mem_reg [led_frame_pkg::pattern_depth];
    logic [7:0] rd_data_reg;

    always_ff @(posedge clock)
    begin
        if (wr_en)
        begin
            mem_reg[wr_addr] <= wr_data;
        end
        rd_data_reg <= mem_reg[rd_addr];
    end

    assign rd_data = rd_data_reg;
endmodule : pattern_ram
`default_nettype wire

// file: rtl/led_frame_map.sv
// led matrix frame map: apb register slave, pattern lookup and sticky status
// assumes completion pulses and lookup inputs come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module led_frame_map (
    input wire logic clock,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scroll_done,
    input wire logic fade_done,
    input wire logic palette_fade_done,
    input wire logic disp_frame,
    input wire logic [2:0] disp_row,
    input wire logic [4:0] disp_col,
    output logic [2:0] duty_level_select,
    output logic blink_invert_enable,
    output logic disp_active,
    output logic interrupt_out
);
    // ============================================================
    // apb slave
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [31:0] prdata_reg, prdata_next;
    logic [7:0] idx;
    logic is_pattern, is_ctrl, is_status, access, wr_low;

    assign idx = paddr[9:2];
    assign is_pattern = (idx >= led_frame_pkg::pattern_first_idx)
        && (idx <= led_frame_pkg::pattern_last_idx);
    assign is_ctrl = (idx == led_frame_pkg::control_one_idx);
    assign is_status = (idx == led_frame_pkg::status_idx);
    // addresses are only word slots here; paddr bits 1:0 and 11:10 take no part
    assign access = psel && penable && pready_reg;
    // a refused access carries its error flag in the same cycle as pready
    assign wr_low = access && pwrite && pstrb[0] && !pslverr_reg;

    logic [2:0] flags_reg, flags_next;
    logic mode_reg, mode_next;
    logic irq_reg, irq_next;
    logic [2:0] clear_bits;

    always_comb
    begin
        // one wait state keeps read data off the combinational path
        pready_next = psel && penable && !pready_reg;
        pslverr_next = pready_next && !(is_pattern || is_ctrl || is_status);
        prdata_next = led_frame_pkg::data_reset;
        if (pready_next && !pwrite && is_status)
        begin
            prdata_next[2:0] = flags_reg;
        end
        else if (pready_next && !pwrite && is_ctrl)
        begin
            prdata_next[led_frame_pkg::mode_pos] = mode_reg;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= led_frame_pkg::data_reset;
        end
        else
        begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    // ============================================================
    // control and sticky status
    assign clear_bits = (wr_low && is_ctrl) ? pwdata[2:0] : 3'h0;

    always_comb
    begin
        mode_next = mode_reg;
        if (wr_low && is_ctrl)
        begin
            mode_next = pwdata[led_frame_pkg::mode_pos];
        end
        // a completion in the same cycle as its clear wins
        flags_next[led_frame_pkg::scroll_pos] = scroll_done
            || (flags_reg[led_frame_pkg::scroll_pos]
            && !clear_bits[led_frame_pkg::scroll_pos]);
        flags_next[led_frame_pkg::fade_pos] = fade_done
            || (flags_reg[led_frame_pkg::fade_pos]
            && !clear_bits[led_frame_pkg::fade_pos]);
        flags_next[led_frame_pkg::palette_pos] = palette_fade_done
            || (flags_reg[led_frame_pkg::palette_pos]
            && !clear_bits[led_frame_pkg::palette_pos]);
        irq_next = |flags_next;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            flags_reg <= led_frame_pkg::flags_reset;
            mode_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            flags_reg <= flags_next;
            mode_reg <= mode_next;
            irq_reg <= irq_next;
        end
    end

    // ============================================================
    // pattern lookup
    logic [7:0] base, row_off, byte_addr, wr_off;
    logic [2:0] row_m1;
    logic [3:0] col_half;
    logic in_layout;
    logic [7:0] rd_data;
    logic valid_d_reg, valid_d_next, upper_d_reg, upper_d_next;
    logic valid_reg, valid_next;
    logic [3:0] nib_reg, nib_next;

    assign row_m1 = disp_row - 3'h1;
    assign col_half = 4'((disp_col - 5'h01) >> 1);
    assign row_off = ({2'b00, row_m1, 3'b000}) + {5'h00, row_m1};

    always_comb
    begin
        if (mode_reg == led_frame_pkg::layout_narrow)
        begin
            base = disp_frame ? led_frame_pkg::narrow_frame2_base
                : led_frame_pkg::pattern_first_idx;
            in_layout = (disp_row != 3'h0) && (disp_row <= led_frame_pkg::narrow_rows)
                && (disp_col != 5'h00) && (disp_col <= led_frame_pkg::narrow_cols);
        end
        else
        begin
            base = disp_frame ? led_frame_pkg::wide_frame2_base
                : led_frame_pkg::pattern_first_idx;
            in_layout = (disp_row != 3'h0) && (disp_row <= led_frame_pkg::wide_rows)
                && (disp_col != 5'h00) && (disp_col <= led_frame_pkg::wide_cols);
        end
        // column seventeen lands on the upper half of byte nine
        byte_addr = base + row_off + {4'h0, col_half};
        valid_d_next = in_layout;
        upper_d_next = disp_col[0];
        valid_next = valid_d_reg;
        // outside the layout nothing is shown, whatever was written
        nib_next = !valid_d_reg ? 4'h0 : (upper_d_reg ? rd_data[7:4] : rd_data[3:0]);
    end

    assign wr_off = idx - led_frame_pkg::pattern_first_idx;

    pattern_ram u_ram (
        .clock(clock),
        .wr_en(wr_low && is_pattern),
        .wr_addr(wr_off[6:0]),
        .wr_data(pwdata[7:0]),
        .rd_addr(7'(byte_addr - led_frame_pkg::pattern_first_idx)),
        .rd_data(rd_data)
    );

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            valid_d_reg <= 1'b0;
            upper_d_reg <= 1'b0;
            valid_reg <= 1'b0;
            nib_reg <= 4'h0;
        end
        else
        begin
            valid_d_reg <= valid_d_next;
            upper_d_reg <= upper_d_next;
            valid_reg <= valid_next;
            nib_reg <= nib_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign interrupt_out = irq_reg;
    assign disp_active = valid_reg;
    assign duty_level_select = nib_reg[2:0];
    assign blink_invert_enable = nib_reg[led_frame_pkg::blink_pos];

    // ============================================================
    // checks
    property p_scroll_set;
        @(posedge clock) disable iff (srst) scroll_done |=> flags_reg[0];
    endproperty
    a_scroll_set: assert property (p_scroll_set) else $error("scroll flag not set");

    property p_scroll_hold;
        @(posedge clock) disable iff (srst)
            flags_reg[0] && !clear_bits[0] |=> flags_reg[0];
    endproperty
    a_scroll_hold: assert property (p_scroll_hold) else $error("scroll flag lost");

    property p_fade_clear;
        @(posedge clock) disable iff (srst)
            clear_bits[1] && !fade_done |=> !flags_reg[1];
    endproperty
    a_fade_clear: assert property (p_fade_clear) else $error("fade flag not cleared");

    property p_fade_set;
        @(posedge clock) disable iff (srst)
            fade_done |=> flags_reg[1] ##1 ($stable(flags_reg[1]) || $past(clear_bits[1]));
    endproperty
    a_fade_set: assert property (p_fade_set) else $error("fade flag not set");

    property p_palette;
        @(posedge clock) disable iff (srst)
            !flags_reg[2] && !palette_fade_done |=> !flags_reg[2];
    endproperty
    a_palette: assert property (p_palette) else $error("palette flag set alone");

    property p_irq_or;
        @(posedge clock) disable iff (srst) ##1 irq_reg == (|flags_reg);
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("irq not or of flags");

    property p_outside;
        @(posedge clock) disable iff (srst)
            (disp_col > led_frame_pkg::wide_cols) |-> ##2 !valid_reg && nib_reg == 4'h0;
    endproperty
    a_outside: assert property (p_outside) else $error("off-layout nibble shown");

    property p_narrow_col;
        @(posedge clock) disable iff (srst)
            mode_reg && $stable(mode_reg) && disp_col == 5'h10 |-> ##2 !valid_reg;
    endproperty
    a_narrow_col: assert property (p_narrow_col) else $error("col 16 active in 15x5");

    property p_wide_addr;
        @(posedge clock) disable iff (srst)
            !mode_reg && !disp_frame && disp_row == 3'h7 && disp_col == 5'h11
            |-> byte_addr == 8'h5E;
    endproperty
    a_wide_addr: assert property (p_wide_addr) else $error("17x7 last led address");

    property p_narrow_end;
        @(posedge clock) disable iff (srst)
            mode_reg && disp_frame && disp_row == 3'h5 && disp_col == 5'h0F
            |-> byte_addr == 8'h78;
    endproperty
    a_narrow_end: assert property (p_narrow_end) else $error("15x5 frame two end");

    property p_frame2_start;
        @(posedge clock) disable iff (srst)
            !mode_reg && disp_frame && disp_row == 3'h1 && disp_col == 5'h01
            |-> byte_addr == 8'h5F;
    endproperty
    a_frame2_start: assert property (p_frame2_start) else $error("17x7 frame two start");

    property p_stride;
        @(posedge clock) disable iff (srst)
            !disp_frame && disp_row == 3'h2 && disp_col == 5'h02 |-> byte_addr == 8'h29;
    endproperty
    a_stride: assert property (p_stride) else $error("row stride wrong");
endmodule : led_frame_map
`default_nettype wire

// file: dv/apb_host_model.sv
// apb host model: drives single register transfers into the frame map
// assumes one rising-edge clock shared with the slave, bus idle at time zero
`timescale 1ns/1ps
`default_nettype none
module apb_host_model (
    input wire logic clock,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ============================================================
    // idle bus
    initial
    begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end
    // ============================================================
    // one transfer; the index is a label, the wire carries four times it
    // no wait limit here: the bench cycle ceiling cuts a hang short
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
        input logic [3:0] strb, output logic [31:0] rd, output logic err);
        @(posedge clock);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= wd;
        pstrb <= strb;
        @(posedge clock);
        penable <= 1'h1;
        @(posedge clock);
        while (pready !== 1'h1)
            @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : xfer
endmodule : apb_host_model
`default_nettype wire

// file: dv/led_frame_map_test.sv
// self-checking bench for the led frame map: status flags, refusals, lookups
// assumes the apb host model drives the bus and the bench drives events and lookups
`timescale 1ns/1ps
`default_nettype none
module led_frame_map_test;
    logic clock = 1'h0;
    logic srst = 1'h1;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [2:0] done_vec = 3'h0;
    logic disp_frame = 1'h0;
    logic [2:0] disp_row = 3'h0;
    logic [4:0] disp_col = 5'h00;
    logic [2:0] duty_level_select;
    logic blink_invert_enable, disp_active, interrupt_out, err;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    always #50 clock = ~clock;
    apb_host_model host_u (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    led_frame_map dut_u (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scroll_done(done_vec[0]),
        .fade_done(done_vec[1]), .palette_fade_done(done_vec[2]), .disp_frame(disp_frame),
        .disp_row(disp_row), .disp_col(disp_col), .duty_level_select(duty_level_select),
        .blink_invert_enable(blink_invert_enable), .disp_active(disp_active),
        .interrupt_out(interrupt_out));
    // ============================================================
    // shared tasks
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        host_u.xfer(1'h1, idx, {24'h00_0000, d}, 4'h1, rd, err);
    endtask : wr
    task automatic status(input logic [2:0] exp);
        host_u.xfer(1'h0, led_frame_pkg::status_idx, 32'h0000_0000, 4'h0, rd, err);
        check(rd, {29'h0, exp}, "status");
        check({31'h0, err}, 32'h0, "status error");
    endtask : status
    task automatic pulse(input logic [2:0] v);
        @(posedge clock);
        done_vec <= v;
        @(posedge clock);
        done_vec <= 3'h0;
        #1;
    endtask : pulse
    function automatic logic [7:0] pat(input logic [7:0] a);
        return a ^ 8'hC3;
    endfunction : pat
    // both frames, rows 0 to 7 and columns 0 to 18 per call; rows and columns outside the layout must read inactive
    task automatic sweep(input logic narrow);
        logic [7:0] base, b;
        logic [3:0] nib;
        logic act;
        for (int f = 0; f < 2; f++)
            for (int r = 0; r < 8; r++)
                for (int c = 0; c < 19; c++)
                begin
                    base = (f == 0) ? 8'h20 : (narrow ? led_frame_pkg::narrow_frame2_base :
                        led_frame_pkg::wide_frame2_base);
                    b = pat(base + 8'(9 * (r - 1) + (c - 1) / 2));
                    act = r > 0 && c > 0 && r <= (narrow ? 5 : 7) && c <= (narrow ? 15 : 17);
                    // outside the layout the outputs must read zero
                    nib = act ? (c[0] ? b[7:4] : b[3:0]) : 4'h0;
                    @(posedge clock);
                    disp_frame <= 1'(f);
                    disp_row <= 3'(r);
                    disp_col <= 5'(c);
                    repeat (2) @(posedge clock);
                    #1;
                    check({31'h0, disp_active}, {31'h0, act}, "active");
                    check({29'h0, duty_level_select}, {29'h0, nib[2:0]}, "duty");
                    check({31'h0, blink_invert_enable}, {31'h0, nib[3]}, "blink");
                end
    endtask : sweep
    // ============================================================
    // timeout
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            miscompares++;
            finish_test();
        end
    end
    // ============================================================
    // main sequence
    initial
    begin
        repeat (10) @(posedge clock);
        srst <= 1'h0;
        status(3'h0);
        check({31'h0, interrupt_out}, 32'h0, "irq after reset");
        $display("test reset done");
        for (int i = 0; i < 3; i++)
        begin
            pulse(3'h1 << i);
            check({31'h0, interrupt_out}, 32'h1, "irq on event");
            status(3'h1 << i);
            wr(led_frame_pkg::control_one_idx, 8'(3'h1 << ((i + 1) % 3)));
            status(3'h1 << i);
            wr(led_frame_pkg::control_one_idx, 8'(3'h1 << i));
            status(3'h0);
            check({31'h0, interrupt_out}, 32'h0, "irq cleared");
        end
        pulse(3'h7);
        wr(led_frame_pkg::control_one_idx, 8'h01);
        status(3'h6);
        check({31'h0, interrupt_out}, 32'h1, "irq with two flags");
        wr(led_frame_pkg::control_one_idx, 8'h06);
        // the clear lands at the access edge; look once it has settled
        #1;
        check({31'h0, interrupt_out}, 32'h0, "irq all cleared");
        // completion in the same cycle as its clear: the set must win
        fork
            wr(led_frame_pkg::control_one_idx, 8'h01);
            begin
                repeat (2) @(posedge clock);
                pulse(3'h1);
            end
        join
        status(3'h1);
        check({31'h0, interrupt_out}, 32'h1, "irq after set and clear");
        wr(led_frame_pkg::control_one_idx, 8'h01);
        status(3'h0);
        $display("test flags done");
        host_u.xfer(1'h0, 8'h10, 32'h0000_0000, 4'h0, rd, err);
        check({31'h0, err}, 32'h1, "unmapped error");
        check(rd, 32'h0000_0000, "unmapped data");
        for (int a = 8'h20; a <= 8'h9D; a++)
            wr(8'(a), pat(8'(a)));
        // a write with the low strobe off must leave the byte alone
        host_u.xfer(1'h1, 8'h20, 32'h0000_00FF, 4'h0, rd, err);
        $display("test fill done");
        sweep(1'h0);
        wr(led_frame_pkg::control_one_idx, 8'h10);
        host_u.xfer(1'h0, led_frame_pkg::control_one_idx, 32'h0000_0000, 4'h0, rd, err);
        check(rd, 32'h0000_0010, "layout read back");
        sweep(1'h1);
        $display("test lookup done");
        finish_test();
    end
endmodule : led_frame_map_test
`default_nettype wire
